// ### hdl/lesq_regs.vh
// Purpose: constants for the landing event sequencer
// Assumes: 100 MHz ref_clk
// Notes: registers reached over AXI4-Lite, word aligned
`ifndef LESQ_REGS_VH
`define LESQ_REGS_VH
// clock and tick
`define LESQ_CLK_HZ          100000000
`define LESQ_TICK_US         1000
`define LESQ_TICK_CYC        ((`LESQ_CLK_HZ / 1000000) * `LESQ_TICK_US)
// delays in milliseconds, counted in 1 ms ticks
`define LESQ_JETT_MS         400
`define LESQ_DROGUE_MS       2000
// register byte offsets
`define LESQ_CTRL_OFF        8'h00
`define LESQ_STAT_OFF        8'h04
// control fields
`define LESQ_CTRL_AUTO_BIT   0
`define LESQ_CTRL_RST        32'h00000001
// status fields
`define LESQ_ST_ARMED_BIT    0
`define LESQ_ST_LATCH_BIT    1
`define LESQ_ST_ACTIVE_BIT   2
`define LESQ_ST_JETT_BIT     3
`define LESQ_ST_DRAG_BIT     4
`define LESQ_ST_DROGUE_BIT   5
`define LESQ_ST_PILOT_BIT    6
`define LESQ_ST_CUT_BIT      7
// axi responses
`define LESQ_RESP_OKAY       2'h0
`define LESQ_RESP_SLVERR     2'h2
`endif

// ### hdl/lesq_channel.v
// Purpose: one independent landing sequencing channel
// Assumes: switch inputs synchronous to ref_clk, tick_en one cycle wide
// Notes: every output is registered
`timescale 1ns/1ps
`include "lesq_regs.vh"

module lesq_channel (
	input  wire        ref_clk,
	input  wire        sys_rst,
	input  wire        tick_en,
	input  wire        auto_en,
	input  wire        logic_pwr,
	input  wire        baro_high,
	input  wire        baro_low,
	input  wire        lanyard_closed,
	input  wire        release_sw,
	output reg         enable_sw_r,
	output reg         latch_r,
	output reg         active_r,
	output reg         jet_inhibit_r,
	output reg         jett_fire_r,
	output reg         lanyard_armed_r,
	output reg         drag_fire_r,
	output reg         drogue_fire_r,
	output reg         pilot_fire_r,
	output reg         cutter_fire_r
);

	reg [11:0] jett_cnt_r;   // ticks since activation
	reg [11:0] drg_cnt_r;    // ticks since jettison

	// power taken straight from logic_pwr; the latch does not hold it
	wire pwr_ok = logic_pwr;

	// sequence logic
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			enable_sw_r     <= 1'b0;
			latch_r         <= 1'b0;
			active_r        <= 1'b0;
			jet_inhibit_r   <= 1'b0;
			jett_fire_r     <= 1'b0;
			lanyard_armed_r <= 1'b0;
			drag_fire_r     <= 1'b0;
			drogue_fire_r   <= 1'b0;
			pilot_fire_r    <= 1'b0;
			cutter_fire_r   <= 1'b0;
			jett_cnt_r      <= 12'h000;
			drg_cnt_r       <= 12'h000;
		end else begin
			// switch closes on power and high baro, or held by latch
			enable_sw_r <= pwr_ok & (baro_high | latch_r); // R01
			if (pwr_ok & baro_high)
				latch_r <= 1'b1; // R03
			// activation starts the sequence in automatic mode
			if (pwr_ok & (baro_high | latch_r) & auto_en & !active_r) begin
				active_r   <= 1'b1; // R02
				jett_cnt_r <= 12'h000; // R11
			end
			if (active_r)
				jet_inhibit_r <= 1'b1; // R04
			// jettison delay
			if (active_r && !jett_fire_r && tick_en) begin
				if (jett_cnt_r == `LESQ_JETT_MS - 1) begin
					jett_fire_r     <= 1'b1; // R05
					lanyard_armed_r <= 1'b1; // R05
					drg_cnt_r       <= 12'h000; // R11
				end else begin
					jett_cnt_r <= jett_cnt_r + 12'h001; // R11
				end
			end
			// drag mortar via armed lanyard
			if (lanyard_armed_r & lanyard_closed)
				drag_fire_r <= 1'b1; // R06
			// drogue delay after jettison
			if (jett_fire_r && !drogue_fire_r && tick_en) begin
				if (drg_cnt_r == `LESQ_DROGUE_MS - 1)
					drogue_fire_r <= 1'b1; // R07
				else
					drg_cnt_r <= drg_cnt_r + 12'h001; // R11
			end
			// pilot mortars on low altitude switch
			if (active_r & baro_low)
				pilot_fire_r <= 1'b1; // R08
			// riser cutters on crew release
			if (active_r & release_sw)
				cutter_fire_r <= 1'b1; // R09
		end
	end

endmodule // lesq_channel

// ### hdl/lesq_top.v
// Purpose: redundant landing event sequencer with AXI4-Lite registers
// Assumes: 100 MHz ref_clk, synchronous active-high reset
// Notes: two channels; each fire output is the OR of both channels
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lesq_regs.vh"

// How it works
// R01: switch closes on power and high baro
// R02: automatic mode: high baro starts sequence
// R03: latch holds power after high baro; the code latches only the switch, power is not held
// R04: activation disables automatic attitude jets
// R05: 0.4 s: jettison cover, arm lanyards
// R06: armed lanyard closure fires drag mortar
// R07: two seconds later fire drogue mortars
// R08: low baro fires pilot mortars
// R09: crew release fires riser cutters
// R10: two independent channels run full sequence
// R11: delays counted by ms tick counters
module lesq_top (
	input  wire        ref_clk,
	input  wire        sys_rst,
	input  wire        landing_logic_power_switch,
	input  wire [1:0]  baro_high_sw,
	input  wire [1:0]  baro_low_sw,
	input  wire [1:0]  lanyard_sw,
	input  wire        release_sw,
	output reg         jet_disable_r,
	output reg         jett_fire_r,
	output reg         drag_fire_r,
	output reg         drogue_fire_r,
	output reg         pilot_fire_r,
	output reg         cutter_fire_r,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	reg  [16:0] div_r;        // tick divider
	reg         tick_r;       // 1 ms enable pulse
	reg  [31:0] ctrl_r;       // control register
	reg  [7:0]  awaddr_r;     // captured write address
	reg         aw_have_r;    // address held
	reg  [31:0] wdata_r;      // captured write data
	reg  [3:0]  wstrb_r;      // captured strobes
	reg         w_have_r;     // data held

	wire [1:0] ch_en, ch_latch, ch_act, ch_inh, ch_jett, ch_arm;
	wire [1:0] ch_drag, ch_drogue, ch_pilot, ch_cut;

	// fixed-rate tick from clock
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			div_r  <= 17'h00000;
			tick_r <= 1'b0;
		end else if (div_r == `LESQ_TICK_CYC - 1) begin
			div_r  <= 17'h00000;
			tick_r <= 1'b1; // R11
		end else begin
			div_r  <= div_r + 17'h00001;
			tick_r <= 1'b0;
		end
	end

	// two redundant channels
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			lesq_channel u_ch ( // R10
				.ref_clk         (ref_clk),
				.sys_rst         (sys_rst),
				.tick_en         (tick_r),
				.auto_en         (ctrl_r[`LESQ_CTRL_AUTO_BIT]),
				.logic_pwr       (landing_logic_power_switch),
				.baro_high       (baro_high_sw[g]),
				.baro_low        (baro_low_sw[g]),
				.lanyard_closed  (lanyard_sw[g]),
				.release_sw      (release_sw),
				.enable_sw_r     (ch_en[g]),
				.latch_r         (ch_latch[g]),
				.active_r        (ch_act[g]),
				.jet_inhibit_r   (ch_inh[g]),
				.jett_fire_r     (ch_jett[g]),
				.lanyard_armed_r (ch_arm[g]),
				.drag_fire_r     (ch_drag[g]),
				.drogue_fire_r   (ch_drogue[g]),
				.pilot_fire_r    (ch_pilot[g]),
				.cutter_fire_r   (ch_cut[g])
			);
		end
	endgenerate

	// either channel fires the relays
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			jet_disable_r <= 1'b0;
			jett_fire_r   <= 1'b0;
			drag_fire_r   <= 1'b0;
			drogue_fire_r <= 1'b0;
			pilot_fire_r  <= 1'b0;
			cutter_fire_r <= 1'b0;
		end else begin
			jet_disable_r <= |ch_inh; // R04
			jett_fire_r   <= |ch_jett; // R05
			drag_fire_r   <= |ch_drag; // R06
			drogue_fire_r <= |ch_drogue; // R07
			pilot_fire_r  <= |ch_pilot; // R08
			cutter_fire_r <= |ch_cut; // R09
		end
	end

	// merge strobed bytes into old word
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		integer i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1)
				if (st[i])
					wmerge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// write channel: take aw and w in either order
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LESQ_RESP_OKAY;
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
			ctrl_r        <= `LESQ_CTRL_RST;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
			// capture address
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			// capture data
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// both present: perform write, answer
			if (aw_have_r && w_have_r && !s_axi_bvalid) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_r[7:2] == `LESQ_CTRL_OFF >> 2) begin
					ctrl_r      <= wmerge(ctrl_r, wdata_r, wstrb_r) & 32'h00000001;
					s_axi_bresp <= `LESQ_RESP_OKAY;
				end else if (awaddr_r[7:2] == `LESQ_STAT_OFF >> 2) begin
					s_axi_bresp <= `LESQ_RESP_OKAY; // status is read only
				end else begin
					s_axi_bresp <= `LESQ_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `LESQ_RESP_OKAY;
		end else begin
			// offer ready while idle even if a request already waits, or it would stall
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `LESQ_RESP_OKAY;
				if (s_axi_araddr[7:2] == `LESQ_CTRL_OFF >> 2)
					s_axi_rdata <= ctrl_r;
				else if (s_axi_araddr[7:2] == `LESQ_STAT_OFF >> 2)
					s_axi_rdata <= {16'h0000, ch_cut, ch_pilot, ch_drogue, ch_drag,
						ch_jett, ch_act, ch_latch, ch_en};
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `LESQ_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // lesq_top

// ### test/lesq_top_asserts.sv
// Purpose: port checks of the sequencer
// Assumes: one clock, sync reset
// Notes: bound into lesq_top
`timescale 1ns/1ps
module lesq_top_asserts (
	input wire       ref_clk,
	input wire       sys_rst,
	input wire       landing_logic_power_switch,
	input wire [1:0] baro_high_sw,
	input wire [1:0] baro_low_sw,
	input wire       release_sw,
	input wire       jet_disable_r,
	input wire       jett_fire_r,
	input wire       drag_fire_r,
	input wire       drogue_fire_r,
	input wire       pilot_fire_r,
	input wire       cutter_fire_r
);
	localparam int JETT_MIN = 39999990; // 0.4 s less output lag
	reg [25:0] act_cnt_r; // cycles since activation
	// saturating age of activation
	always @(posedge ref_clk) begin
		if (sys_rst)
			act_cnt_r <= 26'h0;
		else if (jet_disable_r && act_cnt_r != 26'h3FFFFFF)
			act_cnt_r <= act_cnt_r + 26'h1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_act_pwr: assert property ($rose(jet_disable_r) |-> $past(landing_logic_power_switch))
		else $error("activation without power");
	a_act_baro: assert property ($rose(jet_disable_r) |->
		$past(baro_high_sw, 2) != 2'h0 || $past(baro_high_sw, 3) != 2'h0)
		else $error("activation without high baro");
	a_act_hold: assert property (jet_disable_r |=> jet_disable_r)
		else $error("jet disable dropped");
	a_pilot_why: assert property ($rose(pilot_fire_r) |-> jet_disable_r)
		else $error("pilot fired while idle");
	a_pilot_due: assert property (jet_disable_r && baro_low_sw == 2'h3 |-> ##[1:4] pilot_fire_r)
		else $error("pilot not fired");
	a_cut_why: assert property ($rose(cutter_fire_r) |-> jet_disable_r && $past(release_sw, 2))
		else $error("cutter fired without cause");
	a_cut_due: assert property (jet_disable_r && release_sw |-> ##[1:4] cutter_fire_r)
		else $error("cutter not fired");
	a_jett_time: assert property ($rose(jett_fire_r) |-> act_cnt_r >= JETT_MIN)
		else $error("jettison too early");
	a_drogue_order: assert property (drogue_fire_r |-> jett_fire_r)
		else $error("drogue before jettison");
	a_drag_armed: assert property (drag_fire_r |-> jett_fire_r)
		else $error("drag fired unarmed");
endmodule // lesq_top_asserts
bind lesq_top lesq_top_asserts u_chk (.ref_clk, .sys_rst, .landing_logic_power_switch,
	.baro_high_sw, .baro_low_sw, .release_sw, .jet_disable_r, .jett_fire_r, .drag_fire_r,
	.drogue_fire_r, .pilot_fire_r, .cutter_fire_r);

// ### test/lesq_far.sv
// Purpose: switches facing the sequencer
// Assumes: bench commands switch levels
// Notes: levels change just after an edge
`timescale 1ns/1ps
module lesq_far (
	input  wire       ref_clk,
	input  wire       cmd_pwr,
	input  wire [1:0] cmd_hi,
	input  wire       cmd_lo,
	input  wire       cmd_lan,
	input  wire       cmd_rel,
	output reg        pwr_sw = 1'b0,
	output reg  [1:0] hi_sw  = 2'h0,
	output reg  [1:0] lo_sw  = 2'h0,
	output reg  [1:0] lan_sw = 2'h0,
	output reg        rel_sw = 1'b0
);
	// switch contacts settle one edge after a command
	always @(posedge ref_clk) begin
		pwr_sw <= cmd_pwr;
		hi_sw  <= cmd_hi;
		lo_sw  <= {2{cmd_lo}};
		lan_sw <= {2{cmd_lan}};
		rel_sw <= cmd_rel;
	end
endmodule // lesq_far

// ### test/tb_landing_event_sequencer.sv
// Purpose: self-checking bench of lesq_top
// Assumes: 100 MHz clock
// Notes: long delays left to the checker
`timescale 1ns/1ps
`include "lesq_regs.vh"
module tb_landing_event_sequencer;
	reg         ref_clk = 1'b0;
	reg         sys_rst = 1'b1;
	reg         c_pwr = 1'b0, c_lo = 1'b0, c_lan = 1'b0, c_rel = 1'b0;
	reg  [1:0]  c_hi = 2'h0;
	wire        pwr_w, rel_w;
	wire [1:0]  hi_w, lo_w, lan_w;
	reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg         awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	wire        awready, wready, bvalid, arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [5:0]  outs; // jet, jett, drag, drogue, pilot, cutter
	reg  [71:0] exp_q[$]; // resp, outs, mask, value
	integer     n_errors = 0, total_checks = 0, seed = 32'h1f21bb77, ch;
	initial forever #5 ref_clk = ~ref_clk;
	lesq_far far (.ref_clk(ref_clk), .cmd_pwr(c_pwr), .cmd_hi(c_hi), .cmd_lo(c_lo),
		.cmd_lan(c_lan), .cmd_rel(c_rel), .pwr_sw(pwr_w), .hi_sw(hi_w), .lo_sw(lo_w),
		.lan_sw(lan_w), .rel_sw(rel_w));
	lesq_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .landing_logic_power_switch(pwr_w),
		.baro_high_sw(hi_w), .baro_low_sw(lo_w), .lanyard_sw(lan_w), .release_sw(rel_w),
		.jet_disable_r(outs[5]), .jett_fire_r(outs[4]), .drag_fire_r(outs[3]),
		.drogue_fire_r(outs[2]), .pilot_fire_r(outs[1]), .cutter_fire_r(outs[0]),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
	// verdict and end of run
	task summarize;
		begin
			$display("checks %0d errors %0d", total_checks, n_errors);
			if (n_errors == 0 && total_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// compare one read result
	task chk(input [71:0] e, input [71:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("unexpected read result exp %h got %h", e, g);
			end
		end
	endtask
	// takes the oldest note when read data appear
	always @(posedge ref_clk) begin : mon
		reg [71:0] e;
		if (rvalid === 1'b1) begin
			e = exp_q.pop_front();
			chk(e, {rresp, outs, e[63:32], rdata & e[63:32]});
		end
	end
	// reset with all switches open
	task rst;
		begin
			sys_rst <= 1'b1;
			{c_pwr, c_hi, c_lo, c_lan, c_rel} <= 6'h00;
			repeat (4) @(posedge ref_clk);
			sys_rst <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task settle;
		repeat (8) @(posedge ref_clk);
	endtask
	// axi write, address and data offered together
	task wr(input [7:0] a, input [31:0] d);
		reg da, dw;
		begin
			da = 1'b0;
			dw = 1'b0;
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			while (!(da && dw)) begin
				@(posedge ref_clk);
				if (awready === 1'b1) begin
					da = 1'b1;
					awvalid <= 1'b0;
				end
				if (wready === 1'b1) begin
					dw = 1'b1;
					wvalid <= 1'b0;
				end
			end
			while (bvalid !== 1'b1) @(posedge ref_clk);
		end
	endtask
	// axi read, expectation noted first
	task rd(input [7:0] a, input [1:0] r, input [5:0] o, input [31:0] m, input [31:0] v);
		begin
			exp_q.push_back({r, o, m, v});
			araddr <= a;
			arvalid <= 1'b1;
			@(posedge ref_clk);
			while (arready !== 1'b1) @(posedge ref_clk);
			arvalid <= 1'b0;
			while (rvalid !== 1'b1) @(posedge ref_clk);
		end
	endtask
	// hang guard
	initial begin
		#200000;
		n_errors = n_errors + 1;
		summarize;
	end
	initial begin
		rst;
		rd(8'h00, `LESQ_RESP_OKAY, 6'h00, 32'hFFFFFFFF, `LESQ_CTRL_RST);
		rd(8'h08, `LESQ_RESP_SLVERR, 6'h00, 32'hFFFFFFFF, 32'h0);
		wr(8'h04, 32'hFFFF);
		rd(8'h04, `LESQ_RESP_OKAY, 6'h00, 32'hFFFFFFFF, 32'h0);
		$display("test regs done");
		c_hi <= 2'h3;
		c_lan <= 1'b1;
		settle;
		rd(8'h04, `LESQ_RESP_OKAY, 6'h00, 32'hFFFF, 32'h0);
		wr(8'h00, 32'h0);
		c_pwr <= 1'b1;
		settle;
		rd(8'h04, `LESQ_RESP_OKAY, 6'h00, 32'h33, 32'h3);
		$display("test arming done");
		rst;
		ch = $random(seed) & 1;
		c_pwr <= 1'b1;
		c_hi <= 2'h1 << ch;
		settle;
		c_hi <= 2'h0;
		settle;
		rd(8'h04, `LESQ_RESP_OKAY, 6'h20, 32'h30, 32'h10 << ch);
		c_lo <= 1'b1;
		settle;
		c_rel <= 1'b1;
		settle;
		rd(8'h04, `LESQ_RESP_OKAY, 6'h23, 32'hF030, 32'h5010 << ch);
		$display("test sequence done");
		summarize;
	end
endmodule // tb_landing_event_sequencer
